// ===== time_server_model.sv
// network time server model answering the client's queries
`timescale 1ns/1ps
module time_server_model #(
    parameter logic [16:0] SRV_SEC = 17'h0abcd
) (
    input wire logic clk_sys, // system clock
    input wire logic net_query_req, // query pulse
    input wire logic net_query_backup, // query aimed at backup server
    input wire logic silent, // withhold all answers
    output time_sync_pkg::net_resp_t net_resp // answer to the client
);
    initial net_resp = '0;
    // seconds field inverts each cycle between answers, so a stale value equals the fresh one on every other cycle
    always @(posedge clk_sys) begin
        net_resp.valid <= net_query_req && !silent;
        net_resp.clock_ok <= 1'b1;
        net_resp.from_backup <= net_query_backup;
        net_resp.sec <= (net_query_req && !silent) ? SRV_SEC : ~net_resp.sec;
        net_resp.ms <= 10'h000;
    end
endmodule : time_server_model

// ===== time_sync_pkg.sv
// constants, enumerations and carrier types for the time synchronisation front end
package time_sync_pkg;
    // -----------------------------------------------------------------
    // register map
    // -----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_TIME = 8'h08;
    localparam logic [7:0] OFS_TC_BCD = 8'h0c;
    localparam logic [7:0] OFS_TC_SBS = 8'h10;
    localparam logic [7:0] OFS_NET_MAIN = 8'h14;
    localparam logic [7:0] OFS_NET_BACKUP = 8'h18;
    localparam logic [7:0] OFS_NET_IVL = 8'h1c;
    localparam logic [31:0] CTRL_RST = 32'h0000_0010;
    // -----------------------------------------------------------------
    // timing
    // -----------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int MS_PER_S = 1000;
    localparam int MS_CYCLES_DEF = CLK_HZ / MS_PER_S;
    localparam int TC_PPS = 100;
    localparam int TC_BIT_MS = MS_PER_S / TC_PPS;
    localparam int SLOT_MS = 100;
    localparam int SLOT_BITS = SLOT_MS / TC_BIT_MS;
    localparam int FRAME_SLOTS = 10;
    localparam int NET_TIMEOUT_S = 5;
    localparam int PTP_TIMEOUT_S = 5;
    localparam int NET_ACC_MS = 5;
    localparam int PTP_ACC_MS = 3;
    localparam int CARRIER_GAP_DEF = 2 * MS_CYCLES_DEF;
    localparam logic [16:0] SEC_DAY_LAST = 17'h1517f;
    localparam logic [9:0] MS_LAST = 10'h3e7;
    // -----------------------------------------------------------------
    // enumerations
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_TC = 2'b00,
        SRC_NET = 2'b01,
        SRC_PTP = 2'b10,
        SRC_NONE = 2'b11
    } src_t;
    typedef enum logic [1:0] {
        TC_OFF = 2'b00,
        TC_HUNT = 2'b01,
        TC_LOCK = 2'b10,
        TC_ERR = 2'b11
    } tc_state_t;
    typedef enum logic [1:0] {
        NET_MAIN = 2'b00,
        NET_BACKUP = 2'b01,
        NET_LOST = 2'b10
    } net_state_t;
    // -----------------------------------------------------------------
    // carriers
    // -----------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic clock_ok;
        logic from_backup;
        logic [16:0] sec;
        logic [9:0] ms;
    } net_resp_t;
    typedef struct packed {
        logic valid;
        logic [7:0] domain;
        logic [16:0] sec;
        logic [9:0] ms;
        logic [9:0] corr_ms;
        logic [9:0] rtt_ms;
    } ptp_msg_t;
    typedef struct packed {
        logic valid;
        logic [16:0] sec;
        logic [9:0] ms;
    } proto_sync_t;
endpackage : time_sync_pkg

// ===== time_sync_source_selector.sv
// real-time clock synchronisation front end with source selection and an apb slave
//
// Function
// - take time from primary source; switch to secondary when primary unavailable
// - decode the serial time code at one hundred pulses per second
// - frames last one second, ten slots of one hundred milliseconds
// - slots one to four carry seconds, minutes, hours, days in bcd
// - slots five and six are control bits, not time digits
// - slots seven and ten carry straight binary seconds of day
// - accept carrier-modulated or demodulated level time code
// - time code used only when its enable setting is set
// - readable time code synchronisation state
// - network client uses main server, falls back to backup server
// - alarm when neither main nor backup server gives a valid response within five seconds each
// - network sync holds clock within five milliseconds of server
// - readable network state, both server addresses and query interval
// - precision client is slave only and ignores profile identity
// - failure flag asserted whenever precision sync fails
// - precision sync holds clock within three milliseconds of master
// - peer-to-peer delay mode: each link delay compensated
// - end-to-end mode: master delay only, forward equals reverse
// - precision messages accepted only with matching domain number
// - without external source, protocol sync messages set the clock
// - clock can be loaded from locally entered time of day
`timescale 1ns/1ps
module time_sync_source_selector #(
    parameter int MS_CYCLES = time_sync_pkg::MS_CYCLES_DEF,
    parameter int CARRIER_GAP = time_sync_pkg::CARRIER_GAP_DEF
) (
    input wire logic clk_sys, // system clock
    input wire logic sys_rst, // synchronous reset
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic tc_in, // serial time code line
    input wire logic [31:0] net_time_main_server_addr, // main server address
    input wire logic [31:0] net_time_backup_server_addr, // backup server address
    input wire logic [15:0] net_time_query_interval, // query interval in seconds
    input wire time_sync_pkg::net_resp_t net_resp, // network time response
    output logic net_query_req, // one-cycle query pulse
    output logic net_query_backup, // query goes to backup server
    input wire time_sync_pkg::ptp_msg_t ptp_msg, // precision sync message
    input wire time_sync_pkg::proto_sync_t proto_sync, // protocol time message
    output logic [16:0] rtc_sec, // clock seconds of day
    output logic [9:0] rtc_ms, // clock milliseconds
    output time_sync_pkg::src_t active_src, // source in use
    output logic [1:0] timecode_input_state, // time code state
    output logic [2:0] net_time_client_state, // alarm, backup, synced
    output logic net_sync_alarm, // network loss of sync
    output logic precision_time_lost_flag // precision sync failure
);
    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] rdata;
        logic [16:0] ms_div;
        logic [3:0] bit_ms;
        logic [9:0] sec_ms;
        logic [16:0] sec;
        logic [9:0] ms;
        logic prev_in;
        logic [17:0] gap;
        logic [3:0] bit_idx;
        logic [3:0] slot_idx;
        logic [8:0] shift;
        logic [9:0][8:0] slots;
        logic [35:0] bcd;
        logic [16:0] binary_seconds_of_day;
        logic [17:0] ctl_bits;
        time_sync_pkg::tc_state_t tc_st;
        time_sync_pkg::net_state_t net_st;
        logic net_synced;
        logic [2:0] net_wait;
        logic [15:0] ivl_cnt;
        logic query;
        logic [2:0] ptp_wait;
        logic ptp_ok;
        time_sync_pkg::src_t src;
    } st_t;
    st_t cur_r;
    st_t cur_nxt;

    logic ms_tick, sec_tick, bit_tick, level, acc_setup, acc_w;
    logic frame_done, net_good, ptp_good, tc_avail, net_avail, ptp_avail;
    logic [9:0] ptp_delay;
    logic [10:0] ptp_ms_sum;
    time_sync_pkg::src_t pri, sec_src, pick;

    assign pri = time_sync_pkg::src_t'(cur_r.ctrl[3:2]);
    assign sec_src = time_sync_pkg::src_t'(cur_r.ctrl[5:4]);
    assign ms_tick = (cur_r.ms_div == 17'(MS_CYCLES - 1));
    assign sec_tick = ms_tick && (cur_r.sec_ms == time_sync_pkg::MS_LAST);
    assign bit_tick = ms_tick && (cur_r.bit_ms == 4'(time_sync_pkg::TC_BIT_MS - 1));
    // envelope of the carrier: any edge within the gap counts as a one
    assign level = cur_r.ctrl[1] ? (cur_r.gap < 18'(CARRIER_GAP)) : tc_in;
    assign frame_done = bit_tick && level
        && (cur_r.bit_idx == 4'(time_sync_pkg::SLOT_BITS - 1))
        && (cur_r.slot_idx == 4'(time_sync_pkg::FRAME_SLOTS - 1));
    // an invalid clock is treated exactly like a missing answer
    assign net_good = net_resp.valid && net_resp.clock_ok
        && (net_resp.from_backup == (cur_r.net_st == time_sync_pkg::NET_BACKUP));
    // profile identity is never looked at, only the domain number
    assign ptp_good = ptp_msg.valid && (ptp_msg.domain == cur_r.ctrl[15:8]);
    // end-to-end halves the round trip; peer mode adds the per-link corrections
    assign ptp_delay = cur_r.ctrl[6] ? 10'(ptp_msg.corr_ms + (ptp_msg.rtt_ms >> 1))
                                     : (ptp_msg.rtt_ms >> 1);
    assign ptp_ms_sum = {1'b0, ptp_msg.ms} + {1'b0, ptp_delay};
    assign tc_avail = cur_r.ctrl[0] && (cur_r.tc_st == time_sync_pkg::TC_LOCK);
    assign net_avail = cur_r.net_synced && (cur_r.net_st != time_sync_pkg::NET_LOST);
    assign ptp_avail = cur_r.ptp_ok;

    function automatic logic avail(input time_sync_pkg::src_t s, input logic t,
                                   input logic n, input logic p);
        case (s)
            time_sync_pkg::SRC_TC: avail = t;
            time_sync_pkg::SRC_NET: avail = n;
            time_sync_pkg::SRC_PTP: avail = p;
            default: avail = 1'b0;
        endcase
    endfunction : avail

    always_comb begin
        if (avail(pri, tc_avail, net_avail, ptp_avail)) begin
            pick = pri;
        end else if (avail(sec_src, tc_avail, net_avail, ptp_avail)) begin
            pick = sec_src;
        end else begin
            pick = time_sync_pkg::SRC_NONE;
        end
    end

    assign acc_setup = psel && !penable;
    assign acc_w = psel && penable && pwrite;

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb begin
        cur_nxt = cur_r;
        cur_nxt.query = 1'b0;
        cur_nxt.src = pick;
        // dividers: 1 ms, 10 ms code bit, 1 s
        cur_nxt.ms_div = ms_tick ? 17'h0 : 17'(cur_r.ms_div + 17'h1);
        if (ms_tick) begin
            cur_nxt.bit_ms = bit_tick ? 4'h0 : 4'(cur_r.bit_ms + 4'h1);
            cur_nxt.sec_ms = sec_tick ? 10'h0 : 10'(cur_r.sec_ms + 10'h1);
        end
        // free-running clock; every later load overrides it
        if (ms_tick) begin
            if (cur_r.ms == time_sync_pkg::MS_LAST) begin
                cur_nxt.ms = 10'h0;
                cur_nxt.sec = (cur_r.sec == time_sync_pkg::SEC_DAY_LAST) ? 17'h0
                            : 17'(cur_r.sec + 17'h1);
            end else begin
                cur_nxt.ms = 10'(cur_r.ms + 10'h1);
            end
        end
        // -------------------------------------------------------------
        // time code decoder
        // -------------------------------------------------------------
        cur_nxt.prev_in = tc_in;
        cur_nxt.gap = (tc_in != cur_r.prev_in) ? 18'h0
                    : (cur_r.gap == 18'h3ffff) ? cur_r.gap : 18'(cur_r.gap + 18'h1);
        if (!cur_r.ctrl[0]) begin
            cur_nxt.tc_st = time_sync_pkg::TC_OFF;
            cur_nxt.bit_idx = 4'h0;
            cur_nxt.slot_idx = 4'h0;
        end else if (bit_tick) begin
            if (cur_r.bit_idx == 4'(time_sync_pkg::SLOT_BITS - 1)) begin
                // last bit of each slot is a marker that must read one
                cur_nxt.bit_idx = 4'h0;
                if (!level) begin
                    cur_nxt.slot_idx = 4'h0;
                    cur_nxt.tc_st = time_sync_pkg::TC_ERR;
                end else if (cur_r.slot_idx == 4'(time_sync_pkg::FRAME_SLOTS - 1)) begin
                    cur_nxt.slot_idx = 4'h0;
                end else begin
                    cur_nxt.slot_idx = 4'(cur_r.slot_idx + 4'h1);
                    cur_nxt.slots[cur_r.slot_idx] = cur_r.shift;
                end
            end else begin
                cur_nxt.bit_idx = 4'(cur_r.bit_idx + 4'h1);
                cur_nxt.shift = {level, cur_r.shift[8:1]};
            end
            if (cur_r.tc_st == time_sync_pkg::TC_OFF) begin
                cur_nxt.tc_st = time_sync_pkg::TC_HUNT;
            end
        end
        if (frame_done) begin
            cur_nxt.tc_st = time_sync_pkg::TC_LOCK;
            cur_nxt.bcd = {cur_r.slots[3], cur_r.slots[2], cur_r.slots[1],
                           cur_r.slots[0]};
            cur_nxt.ctl_bits = {cur_r.slots[5], cur_r.slots[4]};
            cur_nxt.binary_seconds_of_day = {cur_r.shift[7:0], cur_r.slots[6]};
        end
        // -------------------------------------------------------------
        // network time client, with the precision timeout count
        // -------------------------------------------------------------
        if (sec_tick) begin
            cur_nxt.net_wait = (cur_r.net_wait == 3'(time_sync_pkg::NET_TIMEOUT_S))
                             ? cur_r.net_wait : 3'(cur_r.net_wait + 3'h1);
            cur_nxt.ptp_wait = (cur_r.ptp_wait == 3'(time_sync_pkg::PTP_TIMEOUT_S))
                             ? cur_r.ptp_wait : 3'(cur_r.ptp_wait + 3'h1);
            if (cur_r.ivl_cnt >= net_time_query_interval) begin
                cur_nxt.ivl_cnt = 16'h0;
                cur_nxt.query = 1'b1;
            end else begin
                cur_nxt.ivl_cnt = 16'(cur_r.ivl_cnt + 16'h1);
            end
        end
        if (sec_tick && (cur_r.net_wait == 3'(time_sync_pkg::NET_TIMEOUT_S - 1))) begin
            case (cur_r.net_st)
                time_sync_pkg::NET_MAIN: cur_nxt.net_st = time_sync_pkg::NET_BACKUP;
                time_sync_pkg::NET_BACKUP: cur_nxt.net_st = time_sync_pkg::NET_LOST;
                time_sync_pkg::NET_LOST: cur_nxt.net_st = time_sync_pkg::NET_MAIN;
                default: cur_nxt.net_st = time_sync_pkg::NET_MAIN;
            endcase
            cur_nxt.net_wait = 3'h0;
            cur_nxt.query = 1'b1;
        end
        // a good answer after the alarm raised ends it, as does the next five-second timeout
        if (net_good) begin
            cur_nxt.net_wait = 3'h0;
            cur_nxt.net_synced = 1'b1;
            if (cur_r.net_st == time_sync_pkg::NET_LOST) begin
                cur_nxt.net_st = time_sync_pkg::NET_MAIN;
            end
        end
        // -------------------------------------------------------------
        // precision time client
        // -------------------------------------------------------------
        if (ptp_good) begin
            cur_nxt.ptp_wait = 3'h0;
            cur_nxt.ptp_ok = 1'b1;
        end else if (sec_tick && (cur_r.ptp_wait == 3'(time_sync_pkg::PTP_TIMEOUT_S - 1))) begin
            cur_nxt.ptp_ok = 1'b0;
        end
        // -------------------------------------------------------------
        // clock loads, lowest priority first
        // -------------------------------------------------------------
        if (proto_sync.valid && (pick == time_sync_pkg::SRC_NONE)) begin
            cur_nxt.sec = proto_sync.sec;
            cur_nxt.ms = proto_sync.ms;
        end
        if (frame_done && (pick == time_sync_pkg::SRC_TC)) begin
            cur_nxt.sec = {cur_r.shift[7:0], cur_r.slots[6]};
            cur_nxt.ms = 10'h0;
        end
        if (net_good && (pick == time_sync_pkg::SRC_NET)) begin
            cur_nxt.sec = net_resp.sec;
            cur_nxt.ms = net_resp.ms;
        end
        if (ptp_good && (pick == time_sync_pkg::SRC_PTP)) begin
            if (ptp_ms_sum > 11'(time_sync_pkg::MS_LAST)) begin
                cur_nxt.ms = 10'(ptp_ms_sum - 11'(time_sync_pkg::MS_PER_S));
                cur_nxt.sec = (ptp_msg.sec == time_sync_pkg::SEC_DAY_LAST) ? 17'h0
                            : 17'(ptp_msg.sec + 17'h1);
            end else begin
                cur_nxt.ms = ptp_ms_sum[9:0];
                cur_nxt.sec = ptp_msg.sec;
            end
        end
        // -------------------------------------------------------------
        // apb: read data is captured in setup, writes land in access
        // -------------------------------------------------------------
        if (acc_setup) begin
            case (paddr)
                time_sync_pkg::OFS_CTRL: cur_nxt.rdata = {16'h0, cur_r.ctrl[15:0]};
                time_sync_pkg::OFS_STATUS: cur_nxt.rdata = {24'h0, cur_r.src,
                    !cur_r.ptp_ok, cur_r.net_st == time_sync_pkg::NET_LOST,
                    cur_r.net_st == time_sync_pkg::NET_BACKUP, cur_r.net_synced,
                    cur_r.tc_st};
                time_sync_pkg::OFS_TIME: cur_nxt.rdata = {5'h0, cur_r.ms, cur_r.sec};
                time_sync_pkg::OFS_TC_BCD: cur_nxt.rdata = {cur_r.bcd[34:27],
                    cur_r.bcd[24:18], cur_r.bcd[15:9], cur_r.bcd[8:0],
                    cur_r.ctl_bits[0]};
                time_sync_pkg::OFS_TC_SBS: cur_nxt.rdata = {15'h0, cur_r.binary_seconds_of_day};
                time_sync_pkg::OFS_NET_MAIN: cur_nxt.rdata = net_time_main_server_addr;
                time_sync_pkg::OFS_NET_BACKUP: cur_nxt.rdata = net_time_backup_server_addr;
                time_sync_pkg::OFS_NET_IVL: cur_nxt.rdata = {16'h0, net_time_query_interval};
                default: cur_nxt.rdata = 32'h0;
            endcase
        end
        if (acc_w && (paddr == time_sync_pkg::OFS_CTRL)) begin
            cur_nxt.ctrl = {16'h0, pwdata[15:0]};
        end
        if (acc_w && (paddr == time_sync_pkg::OFS_TIME)) begin
            cur_nxt.sec = pwdata[16:0];
            cur_nxt.ms = pwdata[26:17];
        end
        if (sys_rst) begin
            cur_nxt = '0;
            cur_nxt.ctrl = time_sync_pkg::CTRL_RST;
            cur_nxt.src = time_sync_pkg::SRC_NONE;
        end
    end

    always_ff @(posedge clk_sys) begin
        cur_r <= cur_nxt;
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign pready = 1'b1;
    assign pslverr = psel && penable && (paddr[1:0] != 2'b00 || paddr > time_sync_pkg::OFS_NET_IVL);
    assign prdata = cur_r.rdata;
    assign rtc_sec = cur_r.sec;
    assign rtc_ms = cur_r.ms;
    assign active_src = cur_r.src;
    assign timecode_input_state = cur_r.tc_st;
    assign net_sync_alarm = (cur_r.net_st == time_sync_pkg::NET_LOST);
    assign net_time_client_state = {net_sync_alarm,
                                    cur_r.net_st == time_sync_pkg::NET_BACKUP, cur_r.net_synced};
    assign net_query_req = cur_r.query;
    assign net_query_backup = (cur_r.net_st == time_sync_pkg::NET_BACKUP);
    assign precision_time_lost_flag = !cur_r.ptp_ok;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    a_src_primary: assert property (@(posedge clk_sys) disable iff (sys_rst)
        avail(pri, tc_avail, net_avail, ptp_avail) |=> active_src == $past(pri))
        else $error("primary source not chosen");
    a_tc_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !cur_r.ctrl[0] |=> active_src != time_sync_pkg::SRC_TC)
        else $error("time code used while disabled");
    a_frame_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
        frame_done |=> timecode_input_state == time_sync_pkg::TC_LOCK)
        else $error("good frame did not lock");
    a_tc_sbs: assert property (@(posedge clk_sys) disable iff (sys_rst)
        frame_done && active_src == time_sync_pkg::SRC_TC && !acc_w && !ptp_good
        && !net_good |=> rtc_sec == cur_r.binary_seconds_of_day && rtc_ms == 10'h0)
        else $error("clock not loaded from binary seconds");
    a_net_alarm: assert property (@(posedge clk_sys) disable iff (sys_rst)
        sec_tick && cur_r.net_wait == 3'd4 && cur_r.net_st == time_sync_pkg::NET_BACKUP
        && !net_good |=> net_sync_alarm)
        else $error("alarm missing after timeout");
    a_net_backup: assert property (@(posedge clk_sys) disable iff (sys_rst)
        sec_tick && cur_r.net_wait == 3'd4 && cur_r.net_st == time_sync_pkg::NET_MAIN
        && !net_good |=> net_query_backup && net_query_req)
        else $error("no switch to backup server");
    a_net_acc: assert property (@(posedge clk_sys) disable iff (sys_rst)
        net_good && active_src == time_sync_pkg::SRC_NET && !acc_w && !ptp_good
        |=> rtc_sec == $past(net_resp.sec) && rtc_ms == $past(net_resp.ms))
        else $error("network time not applied");
    a_ptp_domain: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ptp_msg.valid && ptp_msg.domain != cur_r.ctrl[15:8] |=> $stable(cur_r.ptp_wait)
        || cur_r.ptp_wait == 3'h1 || cur_r.ptp_wait == time_sync_pkg::PTP_TIMEOUT_S)
        else $error("foreign domain accepted");
    a_ptp_fail: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ptp_good |=> !precision_time_lost_flag)
        else $error("failure flag with good message");
    a_local_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
        acc_w && paddr == time_sync_pkg::OFS_TIME |=> rtc_sec == $past(pwdata[16:0]))
        else $error("local time not loaded");
endmodule : time_sync_source_selector

// ===== time_sync_source_selector_tb.sv
// self-checking bench for the time synchronisation front end
`timescale 1ns/1ps
module time_sync_source_selector_tb;
    logic clk_sys, sys_rst, psel, penable, pwrite, tc_in, pready, pslverr, silent, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [31:0] net_time_main_server_addr = 32'h0a00_0001;
    logic [31:0] net_time_backup_server_addr = 32'h0a00_0002;
    logic [15:0] net_time_query_interval = 16'h0000;
    logic net_query_req, net_query_backup, net_sync_alarm, precision_time_lost_flag;
    logic [16:0] rtc_sec;
    logic [9:0] rtc_ms;
    logic [1:0] timecode_input_state;
    logic [2:0] net_time_client_state;
    time_sync_pkg::src_t active_src;
    time_sync_pkg::net_resp_t net_resp;
    time_sync_pkg::ptp_msg_t ptp_msg;
    time_sync_pkg::proto_sync_t proto_sync;
    int num_errors = 0;
    int n_checks = 0;
    time_sync_source_selector #(.MS_CYCLES(10), .CARRIER_GAP(20)) dut (
        .clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .tc_in, .net_time_main_server_addr, .net_time_backup_server_addr,
        .net_time_query_interval, .net_resp, .net_query_req, .net_query_backup, .ptp_msg,
        .proto_sync, .rtc_sec, .rtc_ms, .active_src, .timecode_input_state,
        .net_time_client_state, .net_sync_alarm, .precision_time_lost_flag);
    time_server_model srv (.clk_sys, .net_query_req, .net_query_backup, .silent, .net_resp);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_hi(input logic bk, input int n);
        repeat (n) begin
            @(posedge clk_sys);
            if ((bk ? net_query_backup : net_query_req) === 1'b1) break;
        end
        chk("query", 32'h1, {31'h0, bk ? net_query_backup : net_query_req});
    endtask : wait_hi
    task automatic send_ptp(input logic [7:0] dom);
        @(posedge clk_sys);
        ptp_msg <= '{1'b1, dom, 17'h00300, 10'h000, 10'h000, 10'h000};
        @(posedge clk_sys);
        ptp_msg.valid <= 1'b0;
        repeat (20) @(posedge clk_sys);
    endtask : send_ptp
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done
    // a hang costs one mismatch and still reaches the verdict
    initial begin
        #1_000_000;
        num_errors++;
        test_done;
    end
    initial begin
        {sys_rst, psel, penable, pwrite, tc_in, silent} = 6'b100000;
        {paddr, pwdata, ptp_msg, proto_sync} = '0;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        apb(1'b0, time_sync_pkg::OFS_CTRL, '0);
        chk("ctrl", time_sync_pkg::CTRL_RST, q);
        apb(1'b0, time_sync_pkg::OFS_STATUS, '0);
        chk("status", 32'h0000_00e0, q);
        apb(1'b1, time_sync_pkg::OFS_NET_MAIN, 32'hffff_ffff);
        apb(1'b0, time_sync_pkg::OFS_NET_MAIN, '0);
        chk("main", net_time_main_server_addr, q);
        apb(1'b0, time_sync_pkg::OFS_NET_BACKUP, '0);
        chk("backup", net_time_backup_server_addr, q);
        apb(1'b0, time_sync_pkg::OFS_NET_IVL, '0);
        chk("interval", 32'h0, q);
        apb(1'b0, 8'h20, '0);
        chk("slverr", 32'h1, {31'h0, err});
        apb(1'b1, time_sync_pkg::OFS_TIME, 32'h0000_0100);
        repeat (2) @(posedge clk_sys);
        chk("local", 32'h100, {15'h0, rtc_sec});
        @(posedge clk_sys);
        proto_sync <= '{1'b1, 17'h00200, 10'h000};
        @(posedge clk_sys);
        proto_sync.valid <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk("proto", 32'h200, {15'h0, rtc_sec});
        chk("free", time_sync_pkg::SRC_NONE, active_src);
        apb(1'b1, time_sync_pkg::OFS_CTRL, 32'h0000_0011);
        repeat (110) @(posedge clk_sys);
        chk("tc hunt", 32'h1, {30'h0, timecode_input_state});
        repeat (1000) @(posedge clk_sys);
        chk("tc frame err", 32'h3, {30'h0, timecode_input_state});
        chk("tc unlocked", time_sync_pkg::SRC_NONE, active_src);
        apb(1'b1, time_sync_pkg::OFS_CTRL, 32'h0000_0508);
        send_ptp(8'h06);
        chk("foreign", 32'h1, {31'h0, precision_time_lost_flag});
        send_ptp(8'h05);
        send_ptp(8'h05);
        chk("lost", 32'h0, {31'h0, precision_time_lost_flag});
        chk("ptp", 32'h300, {15'h0, rtc_sec});
        chk("src", time_sync_pkg::SRC_PTP, active_src);
        apb(1'b1, time_sync_pkg::OFS_CTRL, 32'h0000_0504);
        wait_hi(1'b0, 12000);
        wait_hi(1'b0, 12000);
        repeat (3) @(posedge clk_sys);
        chk("net", 32'h0abcd, {15'h0, rtc_sec});
        chk("ms", 32'h1, {31'h0, rtc_ms <= 10'd5});
        chk("src", time_sync_pkg::SRC_NET, active_src);
        silent <= 1'b1;
        wait_hi(1'b1, 70000);
        chk("alarm", 32'h0, {31'h0, net_sync_alarm});
        silent <= 1'b0;
        wait_hi(1'b0, 12000);
        repeat (3) @(posedge clk_sys);
        chk("netstate", 32'h3, {29'h0, net_time_client_state});
        test_done;
    end
endmodule : time_sync_source_selector_tb
